// ===== design/ptc_defs.vh
// Purpose: Constants for the periodic timebase counter block
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Offsets are byte addresses
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH
// Register offsets
`define PTC_OFF_TB_COUNT 8'h36
`define PTC_OFF_TB_CTRL 8'h37
`define PTC_OFF_RL_CTRL 8'h38
`define PTC_OFF_RL_COUNT 8'h39
`define PTC_OFF_RL_VALUE 8'h3a
`define PTC_OFF_EVT_STATUS 8'h3b
`define PTC_OFF_EVT_MASK 8'h3c
// Field positions of the timebase control/status register
`define PTC_BIT_RSVD 7
`define PTC_BIT_CHAIN 6
`define PTC_BIT_ROLLOVER 5
`define PTC_BIT_IRQ_EN 4
`define PTC_BIT_RUN 3
`define PTC_PS_MSB 2
`define PTC_PS_LSB 0
// Field positions of the own registers
`define PTC_BIT_RL_RUN 0
`define PTC_EVT_RL_OVF 0
`define PTC_EVT_TB_ROLL 1
// Reset values
`define PTC_RST_BYTE 8'h00
`define PTC_RST_PS 3'h0
`define PTC_RST_EVT 2'h0
// Top value of the byte counters
`define PTC_TOP 8'hff
`endif

// ===== design/ptc_prescaler.v
// Purpose: Power-of-two prescaler for the timebase
// Assumes: Single clock, asynchronous active-high reset
// Notes: Held cleared while not running so the first tick comes a full period later
`timescale 1ns/1ns
module ptc_prescaler
#(
   parameter WIDTH = 8
)
(
   input wire sys_clk,
   input wire reset,
   input wire run,
   input wire [2:0] sel,
   output wire tick
);
   reg [WIDTH-1:0] div_r;
   reg [WIDTH-1:0] mask;
   integer i;

   // Low bits that must all be ones for a tick; code n divides by 2^(n+1)
   always @*
   begin
      mask = {WIDTH{1'b0}};
      for (i = 0; i < WIDTH; i = i + 1)
      begin
         if (i <= sel)
            mask[i] = 1'b1;
      end
   end

   assign tick = run && ((div_r & mask) == mask);

   // Divider runs freely while enabled, clears when stopped
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         div_r <= {WIDTH{1'b0}};
      else if (!run)
         div_r <= {WIDTH{1'b0}};
      else
         div_r <= div_r + {{(WIDTH-1){1'b0}}, 1'b1};
   end
endmodule

// ===== design/ptc_reload_counter.v
// Purpose: Auto-reload low-byte counter used as the chain carry source
// Assumes: Ticks come from logic on the same clock
// Notes: A software write wins over a tick in the same cycle
`timescale 1ns/1ns
`include "ptc_defs.vh"
module ptc_reload_counter
#(
   parameter WIDTH = 8
)
(
   input wire sys_clk,
   input wire reset,
   input wire tick,
   input wire wr_en,
   input wire [WIDTH-1:0] wr_data,
   input wire [WIDTH-1:0] reload_value,
   output reg [WIDTH-1:0] count,
   output wire overflow
);
   // Passing the top value is the overflow, one cycle pulse
   assign overflow = tick && !wr_en && (count == {WIDTH{1'b1}});

   // Overflow reloads from the programmed value instead of wrapping to zero
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         count <= {WIDTH{1'b0}};
      else if (wr_en)
         count <= wr_data;
      else if (overflow)
         count <= reload_value;
      else if (tick)
         count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
   end
endmodule

// ===== design/ptc_timebase.v
// Purpose: 8-bit periodic timebase counter with chaining and interrupt
// Assumes: Bus strobes, halt and wait levels and the reload tick share sys_clk
// Notes: Read data appear only in the cycle after a read strobe
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "ptc_defs.vh"
module ptc_timebase
#(
   parameter ADDR_W = 8,
   parameter DATA_W = 8
)
(
   input wire sys_clk,
   input wire reset,
   input wire [ADDR_W-1:0] bus_addr,
   input wire [DATA_W-1:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   output wire [DATA_W-1:0] bus_rdata,
   input wire reload_tick,
   input wire wait_mode,
   input wire halt_mode,
   output wire irq,
   output wire wake_req,
   output wire chain_active
);
   // Address match against one register offset
   function hit;
      input [ADDR_W-1:0] addr;
      input [7:0] off;
      begin
         hit = (addr == off[ADDR_W-1:0]);
      end
   endfunction

   // Interrupt condition; shared by the request and the wake output
   function irq_cond;
      input flag;
      input enable;
      input [1:0] status;
      input [1:0] mask;
      begin
         irq_cond = (flag && enable) || ((status & mask) != 2'h0);
      end
   endfunction

   // Timebase registers
   reg [7:0] tb_count_r;
   reg [7:0] tb_count_nxt;
   reg chain_r;
   reg rollover_flag_r;
   reg rollover_flag_nxt;
   reg irq_enable_r;
   reg run_r;
   reg [2:0] prescale_sel_r;
   reg chain_nxt;
   reg irq_enable_nxt;
   reg run_nxt;
   reg [2:0] prescale_sel_nxt;
   // Own registers for the reload counter and the event interrupt
   reg reload_run_r;
   reg reload_run_nxt;
   reg [7:0] reload_value_r;
   reg [7:0] reload_value_nxt;
   reg [1:0] evt_status_r;
   reg [1:0] evt_status_nxt;
   reg [1:0] evt_mask_r;
   reg [1:0] evt_mask_nxt;
   reg [7:0] rdata_r;
   reg [7:0] rdata_nxt;
   reg irq_r;
   reg irq_nxt;
   reg wake_r;
   reg wake_nxt;

   wire active;
   wire run_gate;
   wire tb_src;
   wire ps_tick;
   wire rl_tick;
   wire rl_ovf;
   wire [7:0] rl_count;
   wire tb_step;
   wire tb_wrap;
   wire wr_tb_count;
   wire wr_tb_ctrl;
   wire wr_rl_ctrl;
   wire wr_rl_count;
   wire wr_rl_value;
   wire wr_evt_mask;
   wire rd_tb_ctrl;
   wire rd_evt_status;
   wire [7:0] ctrl_view;

   // Halt stops both counters; wait does not stop counting and only enables the wake output
   assign active = !halt_mode;

   // Write strobes per register
   assign wr_tb_count = bus_wr && hit(bus_addr, `PTC_OFF_TB_COUNT);
   assign wr_tb_ctrl = bus_wr && hit(bus_addr, `PTC_OFF_TB_CTRL);
   assign wr_rl_ctrl = bus_wr && hit(bus_addr, `PTC_OFF_RL_CTRL);
   assign wr_rl_count = bus_wr && hit(bus_addr, `PTC_OFF_RL_COUNT);
   assign wr_rl_value = bus_wr && hit(bus_addr, `PTC_OFF_RL_VALUE);
   assign wr_evt_mask = bus_wr && hit(bus_addr, `PTC_OFF_EVT_MASK);

   // Read strobes that carry a clearing side effect
   assign rd_tb_ctrl = bus_rd && hit(bus_addr, `PTC_OFF_TB_CTRL);
   assign rd_evt_status = bus_rd && hit(bus_addr, `PTC_OFF_EVT_STATUS);

   // Run gate shared by the prescaler and the count step
   assign run_gate = run_r && active;

   // Prescaler held in reset while run is low or the block is halted
   // A new divide code while running does not restart the divider,
   // so the first period after the change may be short
   ptc_prescaler #(
      .WIDTH(8)
   ) u_prescaler (
      .sys_clk(sys_clk),
      .reset(reset),
      .run(run_gate),
      .sel(prescale_sel_r),
      .tick(ps_tick)
   );

   // Low-byte counter clocked by the reload timer tick source
   // It keeps its own run bit, so it counts while the timebase is stopped
   assign rl_tick = reload_tick && reload_run_r && active;

   ptc_reload_counter #(
      .WIDTH(8)
   ) u_reload (
      .sys_clk(sys_clk),
      .reset(reset),
      .tick(rl_tick),
      .wr_en(wr_rl_count),
      .wr_data(bus_wdata[7:0]),
      .reload_value(reload_value_r),
      .count(rl_count),
      .overflow(rl_ovf)
   );

   // Step source: chained uses the low byte carry, else the prescaler
   assign tb_src = chain_r ? rl_ovf : ps_tick;
   assign tb_step = run_gate && tb_src;

   // A count write in the wrap cycle wins, so that cycle raises no flag
   assign tb_wrap = tb_step && !wr_tb_count && (tb_count_r == `PTC_TOP);

   // Count next value; a software write replaces the count at any time
   always @*
   begin
      tb_count_nxt = tb_count_r;
      if (wr_tb_count)
         tb_count_nxt = bus_wdata[7:0];
      else if (tb_step)
         tb_count_nxt = tb_count_r + 8'h01;
   end

   // Rollover flag: a wrap in the clearing read cycle is kept, set wins
   always @*
   begin
      rollover_flag_nxt = rollover_flag_r;
      if (rd_tb_ctrl)
         rollover_flag_nxt = 1'b0;
      if (tb_wrap)
         rollover_flag_nxt = 1'b1;
   end

   // Event status: sticky, cleared by a read, set wins over the clear
   always @*
   begin
      evt_status_nxt = evt_status_r;
      if (rd_evt_status)
         evt_status_nxt = `PTC_RST_EVT;
      if (rl_ovf)
         evt_status_nxt[`PTC_EVT_RL_OVF] = 1'b1;
      if (tb_wrap)
         evt_status_nxt[`PTC_EVT_TB_ROLL] = 1'b1;
   end

   // Control field next values; bits 7 and 5 of a control write are dropped
   always @*
   begin
      chain_nxt = chain_r;
      irq_enable_nxt = irq_enable_r;
      run_nxt = run_r;
      prescale_sel_nxt = prescale_sel_r;
      if (wr_tb_ctrl)
      begin
         chain_nxt = bus_wdata[`PTC_BIT_CHAIN];
         irq_enable_nxt = bus_wdata[`PTC_BIT_IRQ_EN];
         run_nxt = bus_wdata[`PTC_BIT_RUN];
         prescale_sel_nxt = bus_wdata[`PTC_PS_MSB:`PTC_PS_LSB];
      end
   end

   // Reload timer setup and event mask next values
   always @*
   begin
      reload_run_nxt = reload_run_r;
      reload_value_nxt = reload_value_r;
      evt_mask_nxt = evt_mask_r;
      if (wr_rl_ctrl)
         reload_run_nxt = bus_wdata[`PTC_BIT_RL_RUN];
      if (wr_rl_value)
         reload_value_nxt = bus_wdata[7:0];
      if (wr_evt_mask)
         evt_mask_nxt = bus_wdata[1:0];
   end

   // Interrupt next values follow enable and mask writes at once
   // Halt stops the timebase, so no wake is offered there
   always @*
   begin
      irq_nxt = irq_cond(rollover_flag_nxt, irq_enable_nxt,
                         evt_status_nxt, evt_mask_nxt);
      wake_nxt = irq_nxt && wait_mode && !halt_mode;
   end

   // Control/status view; reserved bit tied low
   assign ctrl_view = {1'b0,
                       chain_r,
                       rollover_flag_r,
                       irq_enable_r,
                       run_r,
                       prescale_sel_r};

   // Read mux; unmapped offsets answer zero
   always @*
   begin
      rdata_nxt = 8'h00;
      if (bus_rd)
      begin
         if (hit(bus_addr, `PTC_OFF_TB_COUNT))
            rdata_nxt = tb_count_r;
         else if (hit(bus_addr, `PTC_OFF_TB_CTRL))
            rdata_nxt = ctrl_view;
         else if (hit(bus_addr, `PTC_OFF_RL_CTRL))
            rdata_nxt = {7'h00, reload_run_r};
         else if (hit(bus_addr, `PTC_OFF_RL_COUNT))
            rdata_nxt = rl_count;
         else if (hit(bus_addr, `PTC_OFF_RL_VALUE))
            rdata_nxt = reload_value_r;
         else if (hit(bus_addr, `PTC_OFF_EVT_STATUS))
            rdata_nxt = {6'h00, evt_status_r};
         else if (hit(bus_addr, `PTC_OFF_EVT_MASK))
            rdata_nxt = {6'h00, evt_mask_r};
      end
   end

   // Timebase count and flag
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         tb_count_r <= `PTC_RST_BYTE;
         rollover_flag_r <= 1'b0;
      end
      else
      begin
         tb_count_r <= tb_count_nxt;
         rollover_flag_r <= rollover_flag_nxt;
      end
   end

   // Control fields; the flag position of a write is ignored
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         chain_r <= 1'b0;
         irq_enable_r <= 1'b0;
         run_r <= 1'b0;
         prescale_sel_r <= `PTC_RST_PS;
      end
      else
      begin
         chain_r <= chain_nxt;
         irq_enable_r <= irq_enable_nxt;
         run_r <= run_nxt;
         prescale_sel_r <= prescale_sel_nxt;
      end
   end

   // Reload counter setup and event interrupt registers
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         reload_run_r <= 1'b0;
         reload_value_r <= `PTC_RST_BYTE;
         evt_status_r <= `PTC_RST_EVT;
         evt_mask_r <= `PTC_RST_EVT;
      end
      else
      begin
         evt_status_r <= evt_status_nxt;
         reload_run_r <= reload_run_nxt;
         reload_value_r <= reload_value_nxt;
         evt_mask_r <= evt_mask_nxt;
      end
   end

   // Read data stand one cycle; interrupt outputs registered from state
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         rdata_r <= 8'h00;
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
         wake_r <= wake_nxt;
      end
   end

   assign bus_rdata = rdata_r;
   assign irq = irq_r;
   assign wake_req = wake_r;
   assign chain_active = chain_r;
endmodule

// ===== verification/ptc_props.sv
// Purpose: Checker on the timebase top-level ports
// Assumes: One clock, reset active high
// Notes: Flag state is internal, so rules are tied to bus traffic
`timescale 1ns/1ns
`include "ptc_defs.vh"
module ptc_props
(
   input wire sys_clk,
   input wire reset,
   input wire [7:0] bus_addr,
   input wire [7:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   input wire [7:0] bus_rdata,
   input wire reload_tick,
   input wire wait_mode,
   input wire halt_mode,
   input wire irq,
   input wire wake_req,
   input wire chain_active
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Control register accesses
   sequence ctl_rd;
      bus_rd && bus_addr == `PTC_OFF_TB_CTRL;
   endsequence
   sequence ctl_wr;
      bus_wr && bus_addr == `PTC_OFF_TB_CTRL;
   endsequence
   rdata_idle_a: assert property (!bus_rd |=> bus_rdata == 8'h00)
      else $error("read data not zero outside read");
   unmapped_read_a: assert property (bus_rd && (bus_addr < `PTC_OFF_TB_COUNT ||
      bus_addr > `PTC_OFF_EVT_MASK) |=> bus_rdata == 8'h00)
      else $error("unmapped read not zero");
   rsvd_zero_a: assert property (ctl_rd |=> !bus_rdata[7])
      else $error("reserved bit read as one");
   chain_load_a: assert property (ctl_wr |=> chain_active == $past(bus_wdata[6]))
      else $error("chain output not loaded");
   chain_hold_a: assert property (!bus_wr |=> $stable(chain_active))
      else $error("chain output moved without write");
   halt_wake_a: assert property (halt_mode |=> !wake_req)
      else $error("wake raised in halt");
   wake_irq_a: assert property (wake_req |-> irq && $past(wait_mode))
      else $error("wake without irq in wait");
   irq_fall_a: assert property ($fell(irq) |-> $past(bus_rd || bus_wr))
      else $error("irq fell without access");
   halt_quiet_a: assert property (halt_mode && !bus_wr |=> !$rose(irq))
      else $error("irq rose in halt");
endmodule
bind ptc_timebase ptc_props chk_u (.sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
   .reload_tick(reload_tick), .wait_mode(wait_mode), .halt_mode(halt_mode), .irq(irq),
   .wake_req(wake_req), .chain_active(chain_active));

// ===== verification/tb.sv
// Purpose: Self-checking bench for the periodic timebase counter
// Assumes: 50 ns clock, reset held ten cycles
// Notes: Every scenario is a task that judges its own results
`timescale 1ns/1ns
`include "ptc_defs.vh"
module tb;
   reg sys_clk = 1'b0;
   reg reset = 1'b1;
   reg [7:0] bus_addr = 8'h00;
   reg [7:0] bus_wdata = 8'h00;
   reg bus_wr = 1'b0;
   reg bus_rd = 1'b0;
   reg reload_tick = 1'b0;
   reg wait_mode = 1'b0;
   reg halt_mode = 1'b0;
   wire [7:0] bus_rdata;
   wire irq;
   wire wake_req;
   wire chain_active;
   integer error_cnt = 0;
   integer total_checks = 0;
   integer n;
   integer c;
   ptc_timebase dut_u (.sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .reload_tick(reload_tick), .wait_mode(wait_mode), .halt_mode(halt_mode), .irq(irq),
      .wake_req(wake_req), .chain_active(chain_active));
   // 20 MHz clock
   initial
   begin
      forever #25 sys_clk = ~sys_clk;
   end
   task chk(input [7:0] got, input [7:0] exp);
   begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // Idle edge after the strobe so a strobe is never assigned twice at one edge
   task wr(input [7:0] a, input [7:0] d);
   begin
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      @(posedge sys_clk);
   end
   endtask
   // Data valid only in the cycle after the strobe
   task rd(input [7:0] a, input [7:0] exp);
   begin
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1 chk(bus_rdata, exp);
      @(posedge sys_clk);
   end
   endtask
   // Bounded wait, sampled clear of the edge
   task wait_irq;
   begin
      n = 0;
      while (irq !== 1'b1 && n < 600)
      begin
         @(posedge sys_clk);
         #1 n = n + 1;
      end
   end
   endtask
   task t_fields;
   begin
      rd(8'h36, 8'h00);
      rd(8'h37, 8'h00);
      wr(8'h37, 8'ha7);
      rd(8'h37, 8'h07);
      wr(8'h37, 8'h40);
      chk({7'h00, chain_active}, 8'h01);
      wr(8'h37, 8'h00);
      rd(8'h40, 8'h00);
   end
   endtask
   // Two ticks from fe reach the wrap; window allows three cycles of slack below and one above
   task t_prescale;
   begin
      for (c = 0; c < 8; c = c + 1)
      begin
         wr(8'h36, 8'hfe);
         wr(8'h37, {5'h03, c[2:0]});
         wait_irq;
         chk({7'h00, n >= (4 << c) - 3 && n <= (4 << c) + 1}, 8'h01);
         rd(8'h37, {5'h07, c[2:0]});
         chk({7'h00, irq}, 8'h00);
         wr(8'h37, 8'h00);
      end
   end
   endtask
   task t_freeze;
   begin
      wr(8'h36, 8'h5a);
      repeat (20) @(posedge sys_clk);
      rd(8'h36, 8'h5a);
      wr(8'h37, 8'h0f);
      repeat (10) @(posedge sys_clk);
      rd(8'h36, 8'h5a);
      wr(8'h36, 8'h11);
      rd(8'h36, 8'h11);
      wr(8'h37, 8'h00);
   end
   endtask
   task t_mask;
   begin
      wr(8'h36, 8'hfe);
      wr(8'h37, 8'h08);
      repeat (10) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h00);
      rd(8'h37, 8'h28);
      rd(8'h37, 8'h08);
      wr(8'h37, 8'h00);
   end
   endtask
   // Slowest divider: without halt 600 cycles would give two ticks
   task t_power;
   begin
      wr(8'h36, 8'h10);
      wr(8'h37, 8'h0f);
      halt_mode <= 1'b1;
      repeat (600) @(posedge sys_clk);
      rd(8'h36, 8'h10);
      halt_mode <= 1'b0;
      wait_mode <= 1'b1;
      wr(8'h36, 8'hfe);
      wr(8'h37, 8'h18);
      wait_irq;
      @(posedge sys_clk);
      #1 chk({7'h00, wake_req}, 8'h01);
      halt_mode <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk({7'h00, wake_req}, 8'h00);
      halt_mode <= 1'b0;
      wait_mode <= 1'b0;
      wr(8'h37, 8'h00);
      rd(8'h37, 8'h20);
   end
   endtask
   task t_chain;
   begin
      rd(8'h3b, 8'h02);
      wr(8'h3c, 8'h01);
      wr(8'h3a, 8'hfe);
      wr(8'h39, 8'hfe);
      wr(8'h38, 8'h01);
      wr(8'h36, 8'h00);
      wr(8'h37, 8'h48);
      repeat (20) @(posedge sys_clk);
      repeat (3)
      begin
         reload_tick <= 1'b1;
         @(posedge sys_clk);
         reload_tick <= 1'b0;
         @(posedge sys_clk);
      end
      rd(8'h36, 8'h01);
      rd(8'h39, 8'hff);
      chk({7'h00, irq}, 8'h01);
      rd(8'h3b, 8'h01);
      chk({7'h00, irq}, 8'h00);
      wr(8'h37, 8'h00);
   end
   endtask
   task test_done;
   begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      t_fields;
      t_prescale;
      t_freeze;
      t_mask;
      t_power;
      t_chain;
      test_done;
   end
   // Run needs about 1800 cycles
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      error_cnt = error_cnt + 1;
      test_done;
   end
endmodule
